// ==== bfist_checker.sv ====
module bfist_checker (
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rstn,
  // register bus
  input wire bfist_pkg::bfist_axi_req_t axi_req,
  input wire bfist_pkg::bfist_axi_rsp_t axi_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import bfist_pkg::*;

  // ----------------------------------------------------------------------------
  // handshake events
  // ----------------------------------------------------------------------------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence

  sequence rd_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence

  // ----------------------------------------------------------------------------
  // bus behaviour
  // ----------------------------------------------------------------------------
  chk_read_answer: assert property (rd_taken |=> axi_rsp.rvalid)
    else $error("read answer missing");
  chk_write_answer: assert property (wr_taken |-> ##[1:2] axi_rsp.bvalid)
    else $error("write answer missing");
  chk_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read data dropped");
  chk_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  chk_write_block: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write accepted while response pending");
  chk_read_block: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while data pending");
  chk_ctrl_zero: assert property (rd_taken ##0 axi_req.araddr == BFIST_OFF_CTRL |=>
    axi_rsp.rdata == 32'h0000_0000)
    else $error("control read not zero");
  chk_unmapped_rd: assert property (rd_taken ##0 axi_req.araddr > BFIST_OFF_DREG7 |=>
    axi_rsp.rresp == BFIST_RESP_SLVERR && axi_rsp.rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_unaligned_wr: assert property (wr_taken ##0 axi_req.awaddr[1:0] != 2'h0 |->
    ##[1:2] (axi_rsp.bvalid && axi_rsp.bresp == BFIST_RESP_SLVERR))
    else $error("unaligned write not refused");

endmodule : bfist_checker

bind bfist_decoder bfist_checker chk_u (
  .clk_sys (clk_sys),
  .rstn    (rstn),
  .axi_req (axi_req),
  .axi_rsp (axi_rsp)
);

// ==== bfist_decoder.sv ====
// What this block does
// - offset selector 0: immediate offset 0..31 from extension word.
// - offset selector 1: bits 8:6 name offset register; bits 10:9 must be zero.
// - register offset is a full signed 32-bit value.
// - width selector 1: bits 2:0 name width register; bits 4:3 must be zero.
// - immediate width 1..31 as is, zero means 32.
// - register width taken modulo 32, zero means 32.
// - offset gives starting bit, width gives number of field bits.
// - insert copies low-order source bits, width many, into the field.
// - insert flags come from the inserted value.
// - set flags from old field value, then all field bits become one.
// - test only updates flags, operand unchanged.
// - negative from field top bit, zero if field clear, V and C cleared, X kept.
// - insert and set accept Dn, (An), displacement, indexed, absolute modes only.
// - test additionally accepts PC-relative displacement and indexed modes.
// - insert register field names the source data register.
// - find-first-one register field names the result register.
// - find-first-one returns offset plus leading zeros, or offset plus width.
module bfist_decoder (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // register bus
  input  wire bfist_pkg::bfist_axi_req_t axi_req,
  output bfist_pkg::bfist_axi_rsp_t      axi_rsp
);
  import bfist_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  bfist_state_t state_q;
  bfist_state_t state_d;
  logic [31:0]  d_q [8];
  logic [15:0]  opword_q;
  logic [15:0]  extword_q;
  logic [31:0]  mem_hi_q;
  logic [31:0]  mem_lo_q;
  logic [31:0]  bdisp_q;
  bfist_ccr_t   ccr_q;
  logic         done_q;
  logic         illegal_q;

  // bus slave state
  logic         aw_have_q;
  logic [7:0]   awaddr_q;
  logic         w_have_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= BFIST_OFF_DREG7);
  endfunction : addr_mapped

  function automatic logic [5:0] width_decode(input logic [4:0] raw);
    return (raw == 5'h0) ? BFIST_FULL_WIDTH : {1'b0, raw};
  endfunction : width_decode

  // --------------------------------------------------------------------------
  // instruction decode
  // --------------------------------------------------------------------------
  bfist_op_t   op;
  logic        off_sel;
  logic        wid_sel;
  logic [31:0] off_full;
  logic [5:0]  width;
  logic [2:0]  ea_mode;
  logic [2:0]  ea_reg;
  logic        ea_ok;
  logic        ext_ok;
  logic        illegal;
  logic [2:0]  ext_reg;

  always_comb begin
    unique case (opword_q[15:6])
      BFIST_OPC_TEST:   op = BFIST_OP_TEST;
      BFIST_OPC_SET:    op = BFIST_OP_SET;
      BFIST_OPC_INSERT: op = BFIST_OP_INSERT;
      BFIST_OPC_FFO:    op = BFIST_OP_FFO;
      default:          op = BFIST_OP_NONE;
    endcase
  end

  always_comb begin
    off_sel = extword_q[11];
    wid_sel = extword_q[5];
    ext_reg = extword_q[14:12];
    ea_mode = opword_q[5:3];
    ea_reg  = opword_q[2:0];
    off_full = off_sel ? d_q[extword_q[8:6]] : {27'h0, extword_q[10:6]};
    width   = width_decode(wid_sel ? d_q[extword_q[2:0]][4:0] : extword_q[4:0]);
  end

  always_comb begin
    ext_ok  = !extword_q[15] && !(off_sel && (extword_q[10:9] != 2'h0)) &&
              !(wid_sel && (extword_q[4:3] != 2'h0));
    if ((op == BFIST_OP_SET) || (op == BFIST_OP_TEST)) begin
      ext_ok = ext_ok && (extword_q[14:12] == 3'h0);
    end
    unique case (ea_mode)
      BFIST_EA_DREG, BFIST_EA_IND, BFIST_EA_DISP, BFIST_EA_INDEX: begin
        ea_ok = 1'b1;
      end
      BFIST_EA_EXT: begin
        ea_ok = (ea_reg == BFIST_EA_ABS_W) || (ea_reg == BFIST_EA_ABS_L);
        if ((op == BFIST_OP_TEST) &&
            ((ea_reg == BFIST_EA_PC_DISP) || (ea_reg == BFIST_EA_PC_IDX))) begin
          ea_ok = 1'b1;
        end
      end
      default: ea_ok = 1'b0;
    endcase
    illegal = (op == BFIST_OP_NONE) || !ext_ok || !ea_ok;
  end

  // --------------------------------------------------------------------------
  // field datapath
  // --------------------------------------------------------------------------
  logic        is_dreg;
  logic [63:0] window;
  logic [5:0]  shift;
  logic [31:0] ins_val;
  logic [31:0] field;
  logic        fld_neg;
  logic        fld_zero;
  logic [5:0]  lead;
  logic [63:0] new_window;
  logic [31:0] ins_left;
  logic [31:0] dreg_new;

  always_comb begin
    is_dreg = (ea_mode == BFIST_EA_DREG);
    // register operand wraps, memory operand spans up to five bytes
    window   = is_dreg ? {d_q[ea_reg], d_q[ea_reg]} : {mem_hi_q, mem_lo_q};
    shift    = is_dreg ? {1'b0, off_full[4:0]} : {3'h0, off_full[2:0]};
    ins_val  = (op == BFIST_OP_INSERT) ? d_q[ext_reg] : 32'hffff_ffff;
    ins_left = ins_val << (BFIST_FULL_WIDTH - width);
    // each bit changes in one half at most, so the changed half supplies it
    dreg_new = new_window[63:32] ^ new_window[31:0] ^ d_q[ea_reg];
  end

  bfist_field_unit u_field (
    .window     (window),
    .shift      (shift),
    .width      (width),
    .ins_val    (ins_val),
    .field      (field),
    .neg        (fld_neg),
    .zero       (fld_zero),
    .lead       (lead),
    .new_window (new_window)
  );

  // --------------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------------
  logic wr_fire;
  logic wr_ok;
  logic go;
  logic clr;

  always_comb begin
    axi_rsp.awready = !aw_have_q && !bvalid_q;
    axi_rsp.wready  = !w_have_q && !bvalid_q;
    axi_rsp.bvalid  = bvalid_q;
    axi_rsp.bresp   = bresp_q;
    axi_rsp.arready = !rvalid_q;
    axi_rsp.rvalid  = rvalid_q;
    axi_rsp.rdata   = rdata_q;
    axi_rsp.rresp   = rresp_q;
    // writes commit only while idle so the datapath owns the registers
    wr_fire = aw_have_q && w_have_q && !bvalid_q && (state_q == BFIST_ST_IDLE);
    wr_ok   = addr_mapped(awaddr_q);
    go      = wr_fire && (awaddr_q == BFIST_OFF_CTRL) && wstrb_q[0] && wdata_q[BFIST_CTRL_GO];
    clr     = wr_fire && (awaddr_q == BFIST_OFF_CTRL) && wstrb_q[0] && wdata_q[BFIST_CTRL_CLR];
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 8'h00;
      w_have_q  <= 1'b0;
      wdata_q   <= BFIST_RST_WORD;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= BFIST_RESP_OKAY;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= axi_req.wdata;
        wstrb_q  <= axi_req.wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? BFIST_RESP_OKAY : BFIST_RESP_SLVERR;
      end else if (bvalid_q && axi_req.bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= BFIST_RST_WORD;
      rresp_q  <= BFIST_RESP_OKAY;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= addr_mapped(axi_req.araddr) ? BFIST_RESP_OKAY : BFIST_RESP_SLVERR;
      rdata_q  <= BFIST_RST_WORD;
      if (axi_req.araddr >= BFIST_OFF_DREG0 && addr_mapped(axi_req.araddr)) begin
        rdata_q <= d_q[axi_req.araddr[4:2]];
      end else begin
        unique case (axi_req.araddr)
          BFIST_OFF_STATUS: begin
            rdata_q[4:0]            <= ccr_q;
            rdata_q[BFIST_ST_BUSY]  <= (state_q == BFIST_ST_EXEC);
            rdata_q[BFIST_ST_DONE]  <= done_q;
            rdata_q[BFIST_ST_ILLEGAL] <= illegal_q;
          end
          BFIST_OFF_CCR:    rdata_q[4:0]  <= ccr_q;
          BFIST_OFF_OPWORD: rdata_q[15:0] <= opword_q;
          BFIST_OFF_EXTWRD: rdata_q[15:0] <= extword_q;
          BFIST_OFF_MEMHI:  rdata_q       <= mem_hi_q;
          BFIST_OFF_MEMLO:  rdata_q       <= mem_lo_q;
          BFIST_OFF_BDISP:  rdata_q       <= bdisp_q;
          default:          rdata_q       <= BFIST_RST_WORD;
        endcase
      end
    end else if (rvalid_q && axi_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (state_q)
      BFIST_ST_IDLE: state_d = go ? BFIST_ST_EXEC : BFIST_ST_IDLE;
      BFIST_ST_EXEC: state_d = BFIST_ST_IDLE;
      default:       state_d = BFIST_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= BFIST_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // flags and condition codes
  // --------------------------------------------------------------------------
  logic exec;
  assign exec = (state_q == BFIST_ST_EXEC);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else if (exec) begin
      done_q    <= 1'b1;
      illegal_q <= illegal;
    end else if (clr) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ccr_q <= '0;
    end else if (exec && !illegal) begin
      ccr_q.v <= 1'b0;
      ccr_q.c <= 1'b0;
      if (op == BFIST_OP_INSERT) begin
        ccr_q.n <= ins_left[31];
        ccr_q.z <= (ins_left == 32'h0);
      end else begin
        ccr_q.n <= fld_neg;
        ccr_q.z <= fld_zero;
      end
    end else if (wr_fire && (awaddr_q == BFIST_OFF_CCR) && wstrb_q[0]) begin
      ccr_q <= wdata_q[4:0];
    end
  end

  // --------------------------------------------------------------------------
  // operand write-back
  // --------------------------------------------------------------------------
  logic writes_field;
  assign writes_field = (op == BFIST_OP_INSERT) || (op == BFIST_OP_SET);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        d_q[i] <= BFIST_RST_WORD;
      end
    end else if (exec && !illegal) begin
      if (is_dreg && writes_field) begin
        d_q[ea_reg] <= dreg_new;
      end
      if (op == BFIST_OP_FFO) begin
        d_q[ext_reg] <= off_full + {26'h0, lead};
      end
    end else if (wr_fire && (awaddr_q >= BFIST_OFF_DREG0) && wr_ok) begin
      d_q[awaddr_q[4:2]] <= merge_strb(d_q[awaddr_q[4:2]], wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mem_hi_q <= BFIST_RST_WORD;
      mem_lo_q <= BFIST_RST_WORD;
      bdisp_q  <= BFIST_RST_WORD;
    end else if (exec && !illegal) begin
      bdisp_q <= is_dreg ? BFIST_RST_WORD : 32'($signed(off_full) >>> 3);
      if (!is_dreg && writes_field) begin
        mem_hi_q <= new_window[63:32];
        mem_lo_q <= new_window[31:0];
      end
    end else if (wr_fire && (awaddr_q == BFIST_OFF_MEMHI)) begin
      mem_hi_q <= merge_strb(mem_hi_q, wdata_q, wstrb_q);
    end else if (wr_fire && (awaddr_q == BFIST_OFF_MEMLO)) begin
      mem_lo_q <= merge_strb(mem_lo_q, wdata_q, wstrb_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      opword_q  <= 16'h0000;
      extword_q <= 16'h0000;
    end else if (wr_fire && (awaddr_q == BFIST_OFF_OPWORD)) begin
      opword_q <= 16'(merge_strb({16'h0, opword_q}, wdata_q, wstrb_q));
    end else if (wr_fire && (awaddr_q == BFIST_OFF_EXTWRD)) begin
      extword_q <= 16'(merge_strb({16'h0, extword_q}, wdata_q, wstrb_q));
    end
  end

endmodule : bfist_decoder

// ==== bfist_decoder_tb.sv ====
module bfist_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bfist_pkg::*;

  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

  logic           clk_sys   = 1'b0;
  logic           rstn      = 1'b0;
  bfist_axi_req_t req       = '0;
  bfist_axi_rsp_t rsp;
  int             bad_count = 0;
  int             checks    = 0;
  logic [31:0]    st;
  logic [31:0]    rdv;
  logic [1:0]     rs;
  logic [32:0]    ill_tab [8] = '{
    {BFIST_OPC_SET, 6'o72, 16'h0000, 1'b1},
    {BFIST_OPC_INSERT, 6'o74, 16'h0000, 1'b1},
    {BFIST_OPC_SET, 6'o71, 16'h0000, 1'b0},
    {BFIST_OPC_TEST, 6'o72, 16'h0000, 1'b0},
    {BFIST_OPC_TEST, 6'o73, 16'h0000, 1'b0},
    {BFIST_OPC_TEST, 6'o00, 16'h1000, 1'b1},
    {BFIST_OPC_TEST, 6'o00, 16'h0a00, 1'b1},
    {BFIST_OPC_TEST, 6'o00, 16'h0028, 1'b1}
  };

  always #10 clk_sys = ~clk_sys;

  bfist_decoder dut_u (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .axi_req (req),
    .axi_rsp (rsp)
  );

  // ----------------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1 && !req.bready) req.bready <= 1'b1;
    end while (!(rsp.bvalid === 1'b1 && req.bready === 1'b1));
    req.bready <= 1'b0;
    rs = rsp.bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1 && !req.rready) req.rready <= 1'b1;
    end while (!(rsp.rvalid === 1'b1 && req.rready === 1'b1));
    req.rready <= 1'b0;
    rdv = rsp.rdata;
    rs  = rsp.rresp;
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, rdv)
  endtask : chk_rd

  function automatic logic [7:0] dreg(input logic [2:0] n);
    return BFIST_OFF_DREG0 + {3'b000, n, 2'b00};
  endfunction : dreg

  // preset ccr {x,n,z,v,c} = 1,0,0,1,1 then execute and wait for done
  task automatic run(input logic [15:0] ow, input logic [15:0] ew);
    int n;
    n = 0;
    wr(BFIST_OFF_CTRL, 32'h2);
    wr(BFIST_OFF_CCR, 32'h13);
    wr(BFIST_OFF_OPWORD, {16'h0, ow});
    wr(BFIST_OFF_EXTWRD, {16'h0, ew});
    wr(BFIST_OFF_CTRL, 32'h1);
    do begin
      rd(BFIST_OFF_STATUS);
      st = rdv;
      n++;
    end while (st[BFIST_ST_DONE] !== 1'b1 && n < 50);
  endtask : run

  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    chk_rd(BFIST_OFF_STATUS, 32'h0, "status reset");
    chk_rd(dreg(3'd7), 32'h0, "d7 reset");
    chk_rd(BFIST_OFF_CTRL, 32'h0, "ctrl read");
    rd(8'h40);
    `CHK("unmapped resp", BFIST_RESP_SLVERR, rs)
    wr(8'h22, 32'h1);
    `CHK("unaligned resp", BFIST_RESP_SLVERR, rs)
    wr(BFIST_OFF_OPWORD, 32'hffff_ffff);
    chk_rd(BFIST_OFF_OPWORD, 32'h0000_ffff, "opword width");
    // test, offset 4, width 32 wrapping
    wr(dreg(3'd1), 32'h8765_4321);
    run({BFIST_OPC_TEST, 6'o01}, 16'h0100);
    `CHK("test ccr", 5'h10, st[4:0])
    chk_rd(dreg(3'd1), 32'h8765_4321, "test keeps d1");
    // insert low byte of d2 at offset 28 width 8 of d3
    wr(dreg(3'd2), 32'h1234_56a5);
    wr(dreg(3'd3), 32'h0);
    run({BFIST_OPC_INSERT, 6'o03}, 16'h2708);
    `CHK("insert ccr", 5'h18, st[4:0])
    chk_rd(dreg(3'd3), 32'h5000_000a, "insert d3");
    // set with offset -2 from d5 and width 35 from d6
    wr(dreg(3'd4), 32'h0000_00f0);
    wr(dreg(3'd5), 32'hffff_fffe);
    wr(dreg(3'd6), 32'h0000_0023);
    run({BFIST_OPC_SET, 6'o04}, 16'h0966);
    `CHK("set ccr", 5'h14, st[4:0])
    chk_rd(dreg(3'd4), 32'h8000_00f3, "set d4");
    // find first one, offset 8 width 16, result to d0
    wr(dreg(3'd7), 32'h0004_0000);
    run({BFIST_OPC_FFO, 6'o07}, 16'h0210);
    `CHK("ffo ccr", 5'h10, st[4:0])
    chk_rd(dreg(3'd0), 32'h0000_000d, "ffo d0");
    wr(dreg(3'd7), 32'hff00_00ff);
    run({BFIST_OPC_FFO, 6'o07}, 16'h0210);
    `CHK("ffo empty ccr", 5'h14, st[4:0])
    chk_rd(dreg(3'd0), 32'h0000_0018, "ffo empty d0");
    // insert low byte of d2 into memory, offset -2 from d5, width 8
    run({BFIST_OPC_INSERT, 6'o20}, 16'h2948);
    `CHK("mem insert ccr", 5'h18, st[4:0])
    chk_rd(BFIST_OFF_MEMHI, 32'h0294_0000, "mem insert hi");
    chk_rd(BFIST_OFF_BDISP, 32'hffff_ffff, "mem byte disp");
    foreach (ill_tab[i]) begin
      run(ill_tab[i][32:17], ill_tab[i][16:1]);
      `CHK("done", 1'b1, st[BFIST_ST_DONE])
      `CHK("illegal", ill_tab[i][0], st[BFIST_ST_ILLEGAL])
    end
    test_done();
  end

  initial begin
    #400us;
    bad_count++;
    test_done();
  end

endmodule : bfist_decoder_tb

// ==== bfist_field_unit.sv ====
// ----------------------------------------------------------------------------
// shared constants and types
// ----------------------------------------------------------------------------
package bfist_pkg;

  // register byte offsets
  localparam logic [7:0]  BFIST_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  BFIST_OFF_STATUS = 8'h04;
  localparam logic [7:0]  BFIST_OFF_CCR    = 8'h08;
  localparam logic [7:0]  BFIST_OFF_OPWORD = 8'h0c;
  localparam logic [7:0]  BFIST_OFF_EXTWRD = 8'h10;
  localparam logic [7:0]  BFIST_OFF_MEMHI  = 8'h14;
  localparam logic [7:0]  BFIST_OFF_MEMLO  = 8'h18;
  localparam logic [7:0]  BFIST_OFF_BDISP  = 8'h1c;
  localparam logic [7:0]  BFIST_OFF_DREG0  = 8'h20;
  localparam logic [7:0]  BFIST_OFF_DREG7  = 8'h3c;

  // control and status bit positions
  localparam int unsigned BFIST_CTRL_GO    = 0;
  localparam int unsigned BFIST_CTRL_CLR   = 1;
  localparam int unsigned BFIST_ST_BUSY    = 8;
  localparam int unsigned BFIST_ST_DONE    = 9;
  localparam int unsigned BFIST_ST_ILLEGAL = 10;

  // first opcode word bits 15:6
  localparam logic [9:0]  BFIST_OPC_TEST   = 10'h3a3;
  localparam logic [9:0]  BFIST_OPC_FFO    = 10'h3b7;
  localparam logic [9:0]  BFIST_OPC_SET    = 10'h3bb;
  localparam logic [9:0]  BFIST_OPC_INSERT = 10'h3bf;

  // effective address modes and registers
  localparam logic [2:0]  BFIST_EA_DREG    = 3'b000;
  localparam logic [2:0]  BFIST_EA_IND     = 3'b010;
  localparam logic [2:0]  BFIST_EA_DISP    = 3'b101;
  localparam logic [2:0]  BFIST_EA_INDEX   = 3'b110;
  localparam logic [2:0]  BFIST_EA_EXT     = 3'b111;
  localparam logic [2:0]  BFIST_EA_ABS_W   = 3'b000;
  localparam logic [2:0]  BFIST_EA_ABS_L   = 3'b001;
  localparam logic [2:0]  BFIST_EA_PC_DISP = 3'b010;
  localparam logic [2:0]  BFIST_EA_PC_IDX  = 3'b011;

  localparam logic [31:0] BFIST_RST_WORD   = 32'h0000_0000;
  localparam logic [5:0]  BFIST_FULL_WIDTH = 6'h20;
  localparam logic [1:0]  BFIST_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  BFIST_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BFIST_ST_IDLE = 2'b01,
    BFIST_ST_EXEC = 2'b10
  } bfist_state_t;

  typedef enum logic [2:0] {
    BFIST_OP_NONE   = 3'h0,
    BFIST_OP_TEST   = 3'h1,
    BFIST_OP_SET    = 3'h2,
    BFIST_OP_INSERT = 3'h3,
    BFIST_OP_FFO    = 3'h4
  } bfist_op_t;

  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } bfist_ccr_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } bfist_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bfist_axi_rsp_t;

endpackage : bfist_pkg

// ----------------------------------------------------------------------------
// field extract, flags, leading-zero scan and merge over a 64-bit window
// ----------------------------------------------------------------------------
module bfist_field_unit (
  // operand window and field position
  input  wire logic [63:0] window,
  input  wire logic [5:0]  shift,
  input  wire logic [5:0]  width,
  // value merged into the field
  input  wire logic [31:0] ins_val,
  // results
  output logic      [31:0] field,
  output logic             neg,
  output logic             zero,
  output logic      [5:0]  lead,
  output logic      [63:0] new_window
);
  import bfist_pkg::*;

  logic [5:0]  pad;
  logic [31:0] top_mask;
  logic [63:0] shifted;
  logic [31:0] left;
  logic [63:0] mask64;
  logic [63:0] ins64;

  function automatic logic [5:0] clz32(input logic [31:0] v);
    logic [5:0] n;
    n = 6'd32;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        n = 6'(31 - i);
      end
    end
    return n;
  endfunction : clz32

  always_comb begin
    pad        = BFIST_FULL_WIDTH - width;
    top_mask   = 32'hffff_ffff << pad;
    shifted    = window << shift;
    left       = shifted[63:32] & top_mask;
    field      = left >> pad;
    neg        = left[31];
    zero       = (left == 32'h0);
    lead       = zero ? width : clz32(left);
    mask64     = {top_mask, 32'h0} >> shift;
    ins64      = {ins_val << pad, 32'h0} >> shift;
    new_window = (window & ~mask64) | (ins64 & mask64);
  end

endmodule : bfist_field_unit
